// ===== rtl/sar_host_if.sv
// result fifo and host-side control logic of the sar converter
`timescale 1ns/1ps

module sar_fifo
  import sar_host_pkg::*;
#(
  parameter int WIDTH = RESULT_W,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fifo_state_t;

  fifo_state_t r;
  fifo_state_t n;
  logic push;
  logic pop;

  assign o_in_ready = r.cnt != FULL_CNT;
  assign o_out_valid = r.cnt != '0;
  assign o_out_data = r.mem[r.rd];

  always_comb
  begin
    n = r;
    push = i_in_valid && (r.cnt != FULL_CNT);
    pop = i_out_ready && (r.cnt != '0);
    if (push)
    begin
      n.mem[r.wr] = i_in_data;
      n.wr = r.wr + 1'b1;
    end
    if (pop)
    begin
      n.rd = r.rd + 1'b1;
    end
    case ({push, pop})
      2'b10: n.cnt = r.cnt + 1'b1;
      2'b01: n.cnt = r.cnt - 1'b1;
      default: n.cnt = r.cnt;
    endcase
    if (i_flush)
    begin
      n.wr = '0;
      n.rd = '0;
      n.cnt = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      r <= '0;
    else
      r <= n;
  end
endmodule // sar_fifo

module sar_host_if
  import sar_host_pkg::*;
#(
  parameter int CAL_CYC = CAL_FULL_CYC,
  parameter int INTERLEAVE_CAL_N_CONV = INTERLEAVE_CAL_N_CONV_CNT
)
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_reset_pin,
  input wire logic i_chip_sel_n,
  input wire logic i_read_n,
  input wire logic i_read_address_sel,
  input wire logic i_bus_width_select,
  input wire logic i_range_select,
  input wire logic i_cal,
  input wire logic i_interleave_cal_n,
  input wire logic i_hold_n,
  input wire logic i_cmp_above,
  output logic [DATA_BUS_W-1:0] o_parallel_data_bus,
  output logic o_parallel_data_oe,
  output logic o_end_of_track_n,
  output logic o_end_of_conv_n,
  output logic o_serial_result_out,
  output logic o_serial_clk,
  output logic [RESULT_W-1:0] o_dac_code,
  output logic o_range_bipolar,
  output logic o_hold_active
);
  localparam int RW = RESULT_W;
  localparam int CAL_W = $clog2(CAL_CYC);
  localparam int ICW = $clog2(INTERLEAVE_CAL_N_CONV);
  localparam int EXT_W = $clog2(INTERLEAVE_CAL_N_EXTRA_CYC);
  localparam int TRK_W = $clog2(TRACK_CYC + 1);
  localparam int RST_W = $clog2(RST_MIN_CYC + 1);
  localparam int BI_W = $clog2(RW);
  localparam logic [CAL_W-1:0] CAL_LAST = CAL_W'(CAL_CYC - 1);
  localparam logic [ICW-1:0] ICNT_LAST = ICW'(INTERLEAVE_CAL_N_CONV - 1);
  localparam logic [EXT_W-1:0] EXT_LAST = EXT_W'(INTERLEAVE_CAL_N_EXTRA_CYC - 1);
  localparam logic [TRK_W-1:0] TRK_DONE = TRK_W'(TRACK_CYC);
  localparam logic [RST_W-1:0] RST_DONE = RST_W'(RST_MIN_CYC);
  localparam logic [PH_W-1:0] PH_SAMPLE = PH_W'(BIT_SAMPLE_PH);
  localparam logic [PH_W-1:0] PH_RISE = PH_W'(BIT_RISE_PH);
  localparam logic [PH_W-1:0] PH_LAST = PH_W'(BIT_CYC - 1);
  localparam logic [RW-1:0] MSB_TRIAL = RW'(1) << (RW - 1);

  typedef struct packed {
    pin_sample_t s1;
    pin_sample_t s2;
    logic cs_prev;
    logic hold_prev;
    logic rd_prev;
    logic rd_was_data;
    conv_state_t st;
    logic cal_lat;
    logic interleave_cal_n_lat;
    logic burst_on;
    logic interleave_cal_n_on;
    logic cal_valid;
    logic [CAL_W-1:0] cal_pos;
    logic [ICW-1:0] interleave_cal_n_cnt;
    logic [EXT_W-1:0] ext_cnt;
    logic [BI_W-1:0] bit_idx;
    logic [PH_W-1:0] ph;
    logic [RW-1:0] sar;
    logic [TRK_W-1:0] trk_cnt;
    logic [RST_W-1:0] rst_cnt;
    logic byte_lo;
    logic [RW-1:0] last_word;
    logic push;
    logic [RW-1:0] push_data;
    logic [DATA_BUS_W-1:0] data;
    logic data_oe;
    logic eot_n;
    logic eoc_n;
    logic serial_result_out;
    logic sclk;
    logic [RW-1:0] dac;
    logic bipolar;
    logic hold;
  } host_state_t;

  localparam host_state_t STATE_RST = '{
    s1: PIN_IDLE, s2: PIN_IDLE, cs_prev: 1'b1, hold_prev: 1'b1, rd_prev: 1'b0, rd_was_data: 1'b0,
    st: ST_CAL_RESET, cal_lat: 1'b0, interleave_cal_n_lat: INTERLEAVE_CAL_N_LAT_RST, burst_on: 1'b0,
    interleave_cal_n_on: 1'b0, cal_valid: 1'b0, cal_pos: '0, interleave_cal_n_cnt: '0, ext_cnt: '0,
    bit_idx: '0, ph: '0, sar: '0, trk_cnt: '0, rst_cnt: '0, byte_lo: 1'b0,
    last_word: '0, push: 1'b0, push_data: '0, data: '0, data_oe: 1'b0,
    eot_n: EOT_N_RST, eoc_n: EOC_N_RST, serial_result_out: 1'b0, sclk: 1'b0, dac: '0,
    bipolar: 1'b0, hold: 1'b0};

  host_state_t r;
  host_state_t n;
  pin_sample_t pins;
  logic cs_fall;
  logic cs_rise;
  logic hold_fall;
  logic rd_act;
  logic rd_start;
  logic rd_end;
  logic soft_rst;
  logic finish;
  logic pop;
  logic fifo_in_ready;
  logic fifo_valid;
  logic [RW-1:0] fifo_head;
  logic [RW-1:0] disp_word;
  logic [STATUS_W-1:0] stat;

  assign pins = '{rst: i_reset_pin, cs_n: i_chip_sel_n, rd_n: i_read_n,
    read_address_sel: i_read_address_sel, bus_width_select: i_bus_width_select,
    range_select: i_range_select, cal: i_cal, interleave_cal_n: i_interleave_cal_n,
    hold_n: i_hold_n, cmp_above: i_cmp_above};

  sar_fifo #(
    .WIDTH(RW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_flush(soft_rst),
    .i_in_valid(r.push),
    .o_in_ready(fifo_in_ready),
    .i_in_data(r.push_data),
    .o_out_valid(fifo_valid),
    .i_out_ready(pop),
    .o_out_data(fifo_head)
  );

  always_comb
  begin
    n = r;
    n.s1 = pins;
    n.s2 = r.s1;
    n.cs_prev = r.s2.cs_n;
    n.hold_prev = r.s2.hold_n;
    n.push = 1'b0;
    finish = 1'b0;
    pop = 1'b0;
    cs_fall = r.cs_prev && !r.s2.cs_n;
    cs_rise = !r.cs_prev && r.s2.cs_n;
    hold_fall = r.hold_prev && !r.s2.hold_n;
    rd_act = !r.s2.cs_n && !r.s2.rd_n;
    rd_start = rd_act && !r.rd_prev;
    rd_end = !rd_act && r.rd_prev;
    n.rd_prev = rd_act;
    // reset pin qualified by minimum width
    n.rst_cnt = !r.s2.rst ? '0 : (r.rst_cnt == RST_DONE ? r.rst_cnt : r.rst_cnt + 1'b1);
    soft_rst = (r.s2.rst && r.rst_cnt == RST_DONE) || (!r.s2.cs_n && !r.s2.hold_n && !r.s2.read_address_sel);
    if (cs_rise)
    begin
      n.cal_lat = r.s2.cal;
      n.interleave_cal_n_lat = r.s2.interleave_cal_n;
    end
    // calibration inputs act only through cs edges
    if (cs_fall)
    begin
      n.burst_on = r.cal_lat;
      n.interleave_cal_n_on = !r.interleave_cal_n_lat;
    end
    // range is steered live, calibration untouched
    n.bipolar = r.s2.range_select;
    disp_word = fifo_valid ? fifo_head : r.last_word;
    stat = '0;
    stat[STB_EOC_N] = r.eoc_n;
    stat[STB_FIFO_NE] = fifo_valid;
    stat[STB_FIFO_FULL] = !fifo_in_ready;
    stat[STB_CALIB] = (r.st == ST_CAL_RESET) || (r.st == ST_BURST);
    stat[STB_CONV] = (r.st == ST_CONV) || (r.st == ST_INTERLEAVE_CAL_N);
    stat[STB_INTERLEAVE_CAL_N] = r.interleave_cal_n_on;
    stat[STB_BURST] = r.burst_on;
    stat[STB_CAL_OK] = r.cal_valid;
    // bus only while read and chip select low
    n.data_oe = rd_act;
    n.data = '0;
    if (rd_act)
    begin
      if (!r.s2.read_address_sel)
        n.data = DATA_BUS_W'(stat);
      else if (r.s2.bus_width_select)
        n.data = DATA_BUS_W'(disp_word);
      // upper byte then lower nibble with zeros
      else if (r.byte_lo)
        n.data = DATA_BUS_W'({disp_word[RW-9:0], {(DATA_BUS_W - RW){1'b0}}});
      else
        n.data = DATA_BUS_W'(disp_word[RW-1 -: 8]);
    end
    if (rd_start)
    begin
      n.rd_was_data = r.s2.read_address_sel;
      n.eoc_n = 1'b1;
    end
    if (rd_end && r.rd_was_data)
    begin
      if (r.s2.bus_width_select || r.byte_lo)
        pop = fifo_valid;
      if (!r.s2.bus_width_select)
        n.byte_lo = !r.byte_lo;
      if (pop)
      begin
        n.last_word = fifo_head;
        n.byte_lo = 1'b0;
      end
    end
    if (r.st == ST_IDLE && r.trk_cnt != TRK_DONE)
      n.trk_cnt = r.trk_cnt + 1'b1;
    n.eot_n = !(r.st == ST_IDLE && r.trk_cnt == TRK_DONE);
    // every counter runs on the master clock
    case (r.st)
      ST_CAL_RESET:
      begin
        if (r.cal_pos == CAL_LAST)
        begin
          n.cal_pos = '0;
          n.st = ST_IDLE;
          n.eoc_n = 1'b0;
          n.cal_valid = 1'b1;
          n.trk_cnt = '0;
        end
        else
          n.cal_pos = r.cal_pos + 1'b1;
      end
      ST_IDLE:
      begin
        if (r.burst_on)
          n.st = ST_BURST;
        // hold edge starts a conversion when the fifo has room and burst is off
        else if (hold_fall && fifo_in_ready)
        begin
          n.st = ST_CONV;
          n.sar = '0;
          n.dac = MSB_TRIAL;
          n.bit_idx = BI_W'(RW - 1);
          n.ph = '0;
          n.hold = 1'b1;
          n.eoc_n = 1'b1;
        end
      end
      ST_CONV:
      begin
        n.ph = r.ph + 1'b1;
        // bit goes out as soon as it is decided
        if (r.ph == PH_SAMPLE)
        begin
          n.sar[r.bit_idx] = r.s2.cmp_above;
          n.serial_result_out = r.s2.cmp_above;
        end
        // one serial clock pulse per decided bit
        if (r.ph == PH_RISE)
          n.sclk = 1'b1;
        if (r.ph == PH_LAST)
        begin
          n.sclk = 1'b0;
          n.ph = '0;
          if (r.bit_idx == '0)
          begin
            if (r.interleave_cal_n_on)
            begin
              n.st = ST_INTERLEAVE_CAL_N;
              n.ext_cnt = '0;
            end
            else
              finish = 1'b1;
          end
          else
          begin
            n.bit_idx = r.bit_idx - 1'b1;
            n.dac = r.sar | (RW'(1) << (r.bit_idx - 1'b1));
          end
        end
      end
      ST_INTERLEAVE_CAL_N:
      begin
        n.ext_cnt = r.ext_cnt + 1'b1;
        if (r.ext_cnt == EXT_LAST)
        begin
          finish = 1'b1;
          // cal_valid set again every so many interleaved conversions, no calibration is run
          if (r.interleave_cal_n_cnt == ICNT_LAST)
          begin
            n.interleave_cal_n_cnt = '0;
            n.cal_valid = 1'b1;
          end
          else
            n.interleave_cal_n_cnt = r.interleave_cal_n_cnt + 1'b1;
        end
      end
      ST_BURST:
      begin
        if (!r.burst_on)
        begin
          n.st = ST_IDLE;
          n.trk_cnt = '0;
        end
        else if (r.cal_pos == CAL_LAST)
        begin
          n.cal_pos = '0;
          n.eoc_n = 1'b0;
          n.cal_valid = 1'b1;
        end
        else
          n.cal_pos = r.cal_pos + 1'b1;
      end
      default:
        n.st = ST_IDLE;
    endcase
    // pending calibration is taken up only once back in idle
    if (finish)
    begin
      n.st = ST_IDLE;
      n.push = 1'b1;
      n.push_data = n.sar;
      n.eoc_n = 1'b0;
      n.hold = 1'b0;
      n.trk_cnt = '0;
      if (!fifo_valid)
        n.byte_lo = 1'b0;
    end
    // logic cleared, full calibration on release
    if (soft_rst)
    begin
      n = STATE_RST;
      n.s1 = pins;
      n.s2 = r.s1;
      n.cs_prev = r.s2.cs_n;
      n.hold_prev = r.s2.hold_n;
      n.rd_prev = rd_act;
      n.rst_cnt = r.rst_cnt;
      n.data_oe = r.data_oe && rd_act;
      n.bipolar = r.s2.range_select;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      r <= STATE_RST;
    else
      r <= n;
  end

  assign o_parallel_data_bus = r.data;
  assign o_parallel_data_oe = r.data_oe;
  assign o_end_of_track_n = r.eot_n;
  assign o_end_of_conv_n = r.eoc_n;
  assign o_serial_result_out = r.serial_result_out;
  assign o_serial_clk = r.sclk;
  assign o_dac_code = r.dac;
  assign o_range_bipolar = r.bipolar;
  assign o_hold_active = r.hold;

  a_bus_float_cs: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (r.s2.cs_n || r.s2.rd_n) |=> !r.data_oe) else $error("bus driven while deselected");
  a_status_low_byte: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (rd_act && !r.s2.read_address_sel) |=> (r.data_oe && r.data[15:8] == 8'h00))
    else $error("status read not on low byte");
  a_byte_lsb_pad: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (rd_act && r.s2.read_address_sel && !r.s2.bus_width_select && r.byte_lo)
    |=> (r.data[3:0] == 4'h0 && r.data[15:8] == 8'h00)) else $error("low byte read malformed");
  a_interleave_cal_n_extra: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(r.st == ST_INTERLEAVE_CAL_N) |-> (r.st == ST_INTERLEAVE_CAL_N)[*8]) else $error("interleave stretch too short");
  a_interleave_cal_n_end: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (r.st == ST_INTERLEAVE_CAL_N && r.ext_cnt == EXT_LAST) |=> (r.st == ST_IDLE && !r.eoc_n))
    else $error("interleave stretch wrong length");
  a_burst_no_conv: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (r.st inside {ST_IDLE, ST_BURST} && r.burst_on) |=> (r.st != ST_CONV)) else $error("conversion during burst");
  a_cal_waits_conv: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (r.st == ST_CONV && r.burst_on && !soft_rst && !(r.ph == PH_LAST && r.bit_idx == '0))
    |=> (r.st == ST_CONV)) else $error("conversion cut by calibration");
  a_eoc_busy: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (r.st == ST_CONV) |-> r.eoc_n) else $error("end of conversion low while converting");
  a_sclk_idle: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (r.st != ST_CONV) |-> !r.sclk) else $error("serial clock active outside conversion");
  a_reset_cal: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $fell(soft_rst) |-> (r.st == ST_CAL_RESET && r.cal_pos == '0)) else $error("reset did not start calibration");
  a_eot_track: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !r.eot_n |-> ($past(r.st) == ST_IDLE && $past(r.trk_cnt) == TRK_DONE)) else $error("track done too early");
endmodule // sar_host_if

// ===== rtl/sar_host_pkg.sv
// shared constants, state codes and pin carrier for the converter host interface
package sar_host_pkg;
  localparam int RESULT_W = 12;
  localparam int DATA_BUS_W = 16;
  localparam int STATUS_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_PERIOD_PS = 4000;
  // reset pin must be high this long before it counts
  localparam int RST_MIN_NS = 100;
  localparam int RST_MIN_CYC = (RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // acquisition time after a conversion before track is reported done
  localparam int TRACK_NS = 1000;
  localparam int TRACK_CYC = (TRACK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // one successive approximation step; comparator answer lags the trial code by two clocks
  localparam int BIT_CYC = 6;
  localparam int PH_W = 3;
  localparam int BIT_SAMPLE_PH = 2;
  localparam int BIT_RISE_PH = 3;
  // hold pin low for one clock plus margin
  localparam int HOLD_MARGIN_NS = 50;
  localparam int HOLD_MIN_CYC = (CLK_PERIOD_PS + HOLD_MARGIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int INTERLEAVE_CAL_N_EXTRA_CYC = 20;
  localparam int INTERLEAVE_CAL_N_CONV_CNT = 2014;
  localparam int CAL_FULL_CYC = 58280;
  // status byte layout
  localparam int STB_EOC_N = 0;
  localparam int STB_FIFO_NE = 1;
  localparam int STB_FIFO_FULL = 2;
  localparam int STB_CALIB = 3;
  localparam int STB_CONV = 4;
  localparam int STB_INTERLEAVE_CAL_N = 5;
  localparam int STB_BURST = 6;
  localparam int STB_CAL_OK = 7;
  // output and latch values after reset
  localparam logic EOC_N_RST = 1'b1;
  localparam logic EOT_N_RST = 1'b1;
  localparam logic INTERLEAVE_CAL_N_LAT_RST = 1'b1;

  typedef enum logic [4:0] {
    ST_CAL_RESET = 5'h01,
    ST_IDLE = 5'h02,
    ST_CONV = 5'h04,
    ST_INTERLEAVE_CAL_N = 5'h08,
    ST_BURST = 5'h10
  } conv_state_t;

  typedef struct packed {
    logic rst;
    logic cs_n;
    logic rd_n;
    logic read_address_sel;
    logic bus_width_select;
    logic range_select;
    logic cal;
    logic interleave_cal_n;
    logic hold_n;
    logic cmp_above;
  } pin_sample_t;

  // idle pin levels held by the synchronisers in reset, so no false edge follows it
  localparam pin_sample_t PIN_IDLE = '{rst: 1'b0, cs_n: 1'b1, rd_n: 1'b1, read_address_sel: 1'b1,
    bus_width_select: 1'b0, range_select: 1'b0, cal: 1'b0, interleave_cal_n: 1'b1, hold_n: 1'b1,
    cmp_above: 1'b0};
endpackage

// ===== testbench/sar_host_model.sv
// host bus and analog input model driving the converter pins
`timescale 1ns/1ps

module sar_host_model
  import sar_host_pkg::*;
(
  input wire logic i_clk,
  input wire logic [RESULT_W-1:0] i_dac,
  input wire logic [DATA_BUS_W-1:0] i_bus,
  input wire logic i_oe,
  input wire logic i_busy,
  output logic o_rst,
  output logic o_cs_n,
  output logic o_rd_n,
  output logic o_addr,
  output logic o_bw,
  output logic o_range,
  output logic o_cal,
  output logic o_il_n,
  output logic o_hold_n,
  output logic o_cmp
);
  logic [RESULT_W-1:0] ain = 12'h000;

  initial
  begin
    {o_rst, o_cs_n, o_rd_n, o_addr, o_bw, o_range, o_cal, o_il_n, o_hold_n} = 9'h0F3;
  end

  // comparator keeps a trial bit while the trial is not above the input
  assign o_cmp = (i_dac <= ain);

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // address low only with hold high
  task automatic bus(input logic cs_n, input logic rd_n, input logic a, input logic bw,
    output logic [DATA_BUS_W-1:0] d, output logic oe);
    @(posedge i_clk);
    {o_cs_n, o_rd_n, o_addr, o_bw} <= {cs_n, rd_n, a, bw};
    cyc(5);
    @(negedge i_clk);
    d = i_bus;
    oe = i_oe;
    @(posedge i_clk);
    {o_cs_n, o_rd_n, o_addr} <= 3'h7;
    cyc(5);
  endtask

  // levels flipped while deselected, restored in the same clock as the final latching rise
  task automatic set_cal(input logic c, input logic il_n);
    @(posedge i_clk);
    {o_cal, o_il_n, o_cs_n} <= {c, il_n, 1'b0};
    cyc(4);
    o_cs_n <= 1'b1;
    cyc(4);
    {o_cal, o_il_n} <= {~c, ~il_n};
    cyc(4);
    o_cs_n <= 1'b0;
    cyc(4);
    {o_cal, o_il_n, o_cs_n} <= {c, il_n, 1'b1};
    cyc(4);
  endtask

  // hold low one clock plus margin, busy watched from the start
  task automatic convert(input logic [RESULT_W-1:0] code, output logic ok, output int len);
    ok = 1'b0;
    len = 0;
    ain = code;
    @(posedge i_clk);
    o_hold_n <= 1'b0;
    for (int i = 1; i < 250 && (i <= HOLD_MIN_CYC || !(ok && i_busy !== 1'b1)); i++)
    begin
      @(posedge i_clk);
      if (i == HOLD_MIN_CYC)
        o_hold_n <= 1'b1;
      ok |= (i_busy === 1'b1);
      len += int'(i_busy === 1'b1);
    end
  endtask

  // reset pin held past the minimum time
  task automatic pin_reset;
    @(posedge i_clk);
    o_rst <= 1'b1;
    cyc(RST_MIN_CYC + 8);
    o_rst <= 1'b0;
  endtask

  task automatic set_range(input logic v);
    @(posedge i_clk);
    o_range <= v;
    cyc(4);
  endtask
endmodule // sar_host_model

// ===== testbench/sar_adc_host_interface_tb_top.sv
// self-checking bench for the converter host interface
`timescale 1ns/1ps

module sar_adc_host_interface_tb_top
  import sar_host_pkg::*;
;
  localparam int CAL_T = 40;
  typedef struct packed {
    logic [RESULT_W-1:0] code;
    logic bw;
    logic [DATA_BUS_W-1:0] hi;
    logic [DATA_BUS_W-1:0] lo;
  } row_t;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic rst, cs_n, rd_n, addr, bw, rng, cal, il_n, hold_n, cmp;
  logic [DATA_BUS_W-1:0] bus, d;
  logic [RESULT_W-1:0] dac, sword;
  logic oe, bus_oe, eot_n, eoc_n, sdo, sclk, bip, busy, sclk_q, ok, g;
  int n_errors = 0;
  int compares = 0;
  int sbits = 0;
  int cycles = 0;
  int len, base, n0;
  row_t rows [5] = '{
    '{12'hA5C, 1'b1, 16'h0A5C, 16'h0000},
    '{12'hA5C, 1'b0, 16'h00A5, 16'h00C0},
    '{12'hFFF, 1'b1, 16'h0FFF, 16'h0000},
    '{12'h001, 1'b0, 16'h0000, 16'h0010},
    '{12'h800, 1'b0, 16'h0080, 16'h0000}};

  sar_host_if #(.CAL_CYC(CAL_T), .INTERLEAVE_CAL_N_CONV(3)) i_dut (
    .i_clk(clk), .i_resetn(resetn), .i_reset_pin(rst), .i_chip_sel_n(cs_n),
    .i_read_n(rd_n), .i_read_address_sel(addr), .i_bus_width_select(bw),
    .i_range_select(rng), .i_cal(cal), .i_interleave_cal_n(il_n), .i_hold_n(hold_n),
    .i_cmp_above(cmp), .o_parallel_data_bus(bus), .o_parallel_data_oe(bus_oe),
    .o_end_of_track_n(eot_n), .o_end_of_conv_n(eoc_n), .o_serial_result_out(sdo),
    .o_serial_clk(sclk), .o_dac_code(dac), .o_range_bipolar(bip), .o_hold_active(busy));

  sar_host_model i_host (
    .i_clk(clk), .i_dac(dac), .i_bus(bus), .i_oe(bus_oe), .i_busy(busy),
    .o_rst(rst), .o_cs_n(cs_n), .o_rd_n(rd_n), .o_addr(addr), .o_bw(bw),
    .o_range(rng), .o_cal(cal), .o_il_n(il_n), .o_hold_n(hold_n), .o_cmp(cmp));

  initial
  begin
    forever #2 clk = ~clk;
  end

  // serial bits captured on each serial clock rise
  always @(posedge clk)
  begin
    sclk_q <= sclk;
    if (sclk === 1'b1 && sclk_q === 1'b0)
    begin
      sword <= {sword[RESULT_W-2:0], sdo};
      sbits <= sbits + 1;
    end
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      close_out();
    end
  end

  task automatic chk_bus(input logic [DATA_BUS_W-1:0] got, input logic [DATA_BUS_W-1:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_bus({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic chk_cnt(input int got, input int exp);
    chk_bus(16'(got), 16'(exp));
  endtask

  task automatic wait_eoc(output logic f);
    f = 1'b0;
    for (int i = 0; i < CAL_T + 30 && !f; i++)
    begin
      @(negedge clk);
      f = (eoc_n === 1'b0);
    end
  endtask

  task automatic close_out;
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(negedge clk);
    chk_bit(eoc_n, 1'b1);
    wait_eoc(g);
    chk_bit(g, 1'b1);
    for (int r = 0; r < 5; r++)
    begin
      n0 = sbits;
      i_host.convert(rows[r].code, ok, len);
      if (r == 0)
        base = len;
      repeat (3) @(negedge clk);
      chk_bit(ok, 1'b1);
      chk_cnt(sbits - n0, RESULT_W);
      chk_bus(16'(sword), 16'(rows[r].code));
      chk_bit(eoc_n, 1'b0);
      chk_bit(eot_n, 1'b1);
      i_host.bus(1'b0, 1'b0, 1'b1, rows[r].bw, d, oe);
      chk_bit(oe, 1'b1);
      chk_bus(d, rows[r].hi);
      chk_bit(eoc_n, 1'b1);
      if (!rows[r].bw)
      begin
        i_host.bus(1'b0, 1'b0, 1'b1, 1'b0, d, oe);
        chk_bus(d, rows[r].lo);
        i_host.bus(1'b0, 1'b0, 1'b1, 1'b0, d, oe);
        chk_bus(d, rows[r].hi);
      end
    end
    i_host.bus(1'b1, 1'b0, 1'b1, 1'b1, d, oe);
    chk_bit(oe, 1'b0);
    i_host.bus(1'b0, 1'b1, 1'b1, 1'b1, d, oe);
    chk_bit(oe, 1'b0);
    // interleave on: longer conversion, mode shown in status
    i_host.set_cal(1'b0, 1'b0);
    i_host.convert(12'h3C3, ok, len);
    chk_cnt(len, base + INTERLEAVE_CAL_N_EXTRA_CYC);
    i_host.bus(1'b0, 1'b0, 1'b0, 1'b1, d, oe);
    chk_bus(d & 16'hFF22, 16'h0022);
    i_host.bus(1'b0, 1'b0, 1'b1, 1'b1, d, oe);
    chk_bus(d, 16'h03C3);
    i_host.set_cal(1'b0, 1'b1);
    // burst on blocks conversions until latched off
    i_host.set_cal(1'b1, 1'b1);
    i_host.bus(1'b0, 1'b0, 1'b0, 1'b0, d, oe);
    chk_bus(d & 16'h0040, 16'h0040);
    i_host.convert(12'h555, ok, len);
    chk_bit(ok, 1'b0);
    i_host.set_cal(1'b0, 1'b1);
    i_host.convert(12'h555, ok, len);
    chk_bit(ok, 1'b1);
    i_host.bus(1'b0, 1'b0, 1'b1, 1'b1, d, oe);
    chk_bus(d, 16'h0555);
    // calibration requested mid-conversion
    fork
      i_host.convert(12'h6A9, ok, len);
      i_host.set_cal(1'b1, 1'b1);
    join
    chk_cnt(len, base);
    i_host.bus(1'b0, 1'b0, 1'b1, 1'b1, d, oe);
    chk_bus(d, 16'h06A9);
    i_host.set_cal(1'b0, 1'b1);
    i_host.set_range(1'b1);
    chk_bit(bip, 1'b1);
    i_host.convert(12'h7FE, ok, len);
    for (len = 0; len < 300 && eot_n !== 1'b0; len++)
      @(negedge clk);
    chk_bit(eot_n, 1'b0);
    chk_bit(1'(len >= TRACK_CYC - 5), 1'b1);
    i_host.bus(1'b0, 1'b0, 1'b1, 1'b1, d, oe);
    chk_bus(d, 16'h07FE);
    i_host.set_range(1'b0);
    chk_bit(bip, 1'b0);
    // fill the result buffer until refused, then drain it
    for (int i = 0; i <= FIFO_DEPTH; i++)
    begin
      i_host.convert(12'h100 + 12'(i), ok, len);
      chk_bit(ok, 1'(i < FIFO_DEPTH));
    end
    i_host.bus(1'b0, 1'b0, 1'b0, 1'b1, d, oe);
    chk_bus(d & 16'h0006, 16'h0006);
    for (int i = 0; i < FIFO_DEPTH; i++)
    begin
      i_host.bus(1'b0, 1'b0, 1'b1, 1'b1, d, oe);
      chk_bus(d, 16'h0100 + 16'(i));
    end
    i_host.bus(1'b0, 1'b0, 1'b0, 1'b1, d, oe);
    chk_bus(d & 16'h0006, 16'h0000);
    // pin reset flushes results and recalibrates
    i_host.convert(12'h0F0, ok, len);
    i_host.pin_reset();
    i_host.cyc(4);
    chk_bit(eoc_n, 1'b1);
    wait_eoc(g);
    chk_bit(g, 1'b1);
    i_host.bus(1'b0, 1'b0, 1'b0, 1'b1, d, oe);
    chk_bus(d & 16'h0002, 16'h0000);
    close_out();
  end
endmodule // sar_adc_host_interface_tb_top
